/* File: hw/seq_regs.vh */
// constants for the instruction sequencer; the flag unit uses none of them
// assumes inclusion by bare name from the design files
`ifndef SEQ_REGS_VH
`define SEQ_REGS_VH
`define CLK_PER_MC 3'h4
`define PHASE_FETCH 2'h0
`define PHASE_LAST 2'h3
`define OP_NOP 8'h00
`define OP_ADD_IMM 8'h24
`define OP_ADD_DIR 8'h25
`define OP_ADDC_IMM 8'h34
`define OP_ADDC_DIR 8'h35
`define OP_SUBB_IMM 8'h94
`define OP_SUBB_DIR 8'h95
`define OP_MUL 8'ha4
`define OP_DIV 8'h84
`define OP_DA 8'hd4
`define OP_RRC 8'h13
`define OP_RLC 8'h33
`define OP_CLR_C 8'hc3
`define OP_SETB_C 8'hd3
`define OP_CPL_C 8'hb3
`define OP_LJMP 8'h02
`define OP_LCALL 8'h12
`define OP_SJMP 8'h80
`define HI_ADD 4'h2
`define HI_ADDC 4'h3
`define HI_SUBB 4'h9
`define LO_AJMP 5'h01
`define LO_ACALL 5'h11
`define PSW_RESET 8'h00
`define ACC_RESET 8'h00
`define PC_RESET 16'h0000
`endif

/* File: hw/flag_alu.v */
// flag unit: add, add with carry and subtract with borrow; other selects pass acc and carry through
// assumes a combinational use by the sequencer on the same clock
`timescale 1ns/1ps
module flag_alu (
  input wire [2:0] op_sel,
  input wire [7:0] acc,
  input wire [7:0] operand,
  input wire cy_in,
  output reg [7:0] result,
  output reg cy_out,
  output reg ov_out,
  output reg ac_out
);
  reg [8:0] sum;
  reg [4:0] nib;
  reg [7:0] b;
  reg ci;
  // 0 add, 1 addc, 2 subb, others pass acc
  always @* begin
    b = (op_sel == 3'h2) ? ~operand : operand;
    ci = (op_sel == 3'h0) ? 1'b0 : ((op_sel == 3'h2) ? ~cy_in : cy_in);
    sum = {1'b0, acc} + {1'b0, b} + {8'h00, ci};
    nib = {1'b0, acc[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    result = acc;
    cy_out = cy_in;
    ov_out = 1'b0;
    ac_out = 1'b0;
    if (op_sel <= 3'h2) begin
      result = sum[7:0];
      cy_out = (op_sel == 3'h2) ? ~sum[8] : sum[8];
      ac_out = (op_sel == 3'h2) ? ~nib[4] : nib[4];
      ov_out = (acc[7] == b[7]) && (sum[7] != acc[7]);
    end
  end
endmodule

/* File: hw/instr_seq.v */
// instruction sequencer: machine cycle timing, fetch control and flags
// Overview of operation
// RULE1: machine cycle is four clock periods
// RULE2: at most one code fetch per machine cycle
// RULE3: cycles equal bytes for ordinary instructions
// RULE4: jumps and calls add one address cycle
// RULE5: operations and flags match reference instruction set; mul and div only set flags and leave acc unchanged, da does nothing
// RULE6: listed flags follow the computed result
// RULE7: per-instruction carry, overflow, auxiliary effects
// RULE8: nop and add forms: listed bytes and cycles
// RULE9: two-bit phase counter marks fetch and end
// assumes code memory answers a fetch within the same machine cycle
`timescale 1ns/1ps
`include "seq_regs.vh"
module instr_seq (
  input wire clk,
  input wire nrst,
  input wire [7:0] code_data,
  input wire [7:0] reg_operand,
  output reg [15:0] fetch_addr,
  output wire fetch_req,
  output reg [7:0] acc,
  output reg [7:0] psw,
  output reg [2:0] phase_full,
  output wire cycle_end,
  output reg instr_done
);
  localparam ST_OPC = 3'b001;
  localparam ST_OPND = 3'b010;
  localparam ST_CALC = 3'b100;
  reg [1:0] phase;
  reg [2:0] state;
  reg [7:0] opcode;
  reg [1:0] bytes_left;
  reg [7:0] opnd_first;
  reg [7:0] code_sync1;
  reg [7:0] code_sync;
  reg [2:0] alu_sel;
  reg [7:0] alu_b;
  reg [1:0] next_len;
  reg next_jump;
  reg [7:0] dec_op;
  wire [7:0] alu_res;
  wire alu_cy;
  wire alu_ov;
  wire alu_ac;
  wire fetch_point;
  ////////////////////////////////////////////////////////////////////
  // phase counter, wraps every four clocks
  always @(posedge clk) begin
    if (!nrst) begin
      phase <= `PHASE_FETCH;
    end else begin
      phase <= phase + 2'h1; // RULE9 RULE1
    end
  end
  assign fetch_point = (phase == `PHASE_FETCH); // RULE9
  assign cycle_end = (phase == `PHASE_LAST); // RULE9 RULE1
  // one fetch request only at the fetch point, never in address cycles
  assign fetch_req = fetch_point && (state != ST_CALC) && nrst; // RULE2
  ////////////////////////////////////////////////////////////////////
  // code bytes come from a pin bus, synchronised before use
  always @(posedge clk) begin
    if (!nrst) begin
      code_sync1 <= 8'h00;
      code_sync <= 8'h00;
    end else begin
      code_sync1 <= code_data;
      code_sync <= code_sync1;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // length decode from the opcode byte held at cycle end
  always @* begin
    dec_op = (state == ST_OPC) ? code_sync : opcode;
    next_len = 2'h1; // RULE8 RULE3
    next_jump = 1'b0;
    case (dec_op)
      `OP_ADD_IMM, `OP_ADD_DIR, `OP_ADDC_IMM, `OP_ADDC_DIR,
      `OP_SUBB_IMM, `OP_SUBB_DIR: next_len = 2'h2; // RULE8
      `OP_SJMP: begin
        next_len = 2'h2;
        next_jump = 1'b1; // RULE4
      end
      `OP_LJMP, `OP_LCALL: begin
        next_len = 2'h3;
        next_jump = 1'b1; // RULE4
      end
      default: begin
        if (dec_op[4:0] == `LO_AJMP || dec_op[4:0] == `LO_ACALL) begin
          next_len = 2'h2;
          next_jump = 1'b1; // RULE4
        end
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////
  // alu operand and function select; an immediate is the byte taken at this cycle end
  always @* begin
    alu_b = (opcode[3] || !opcode[2] || opcode[1]) ? reg_operand : code_sync;
    if (opcode[3:0] == 4'h5) begin
      alu_b = reg_operand;
    end
    case (opcode[7:4])
      `HI_ADD: alu_sel = 3'h0; // RULE7
      `HI_ADDC: alu_sel = 3'h1; // RULE7
      `HI_SUBB: alu_sel = 3'h2; // RULE7
      default: alu_sel = 3'h7;
    endcase
    if (opcode[3:0] < 4'h4) begin
      alu_sel = 3'h7;
    end
  end
  flag_alu u_alu (
    .op_sel(alu_sel),
    .acc(acc),
    .operand(alu_b),
    .cy_in(psw[7]),
    .result(alu_res),
    .cy_out(alu_cy),
    .ov_out(alu_ov),
    .ac_out(alu_ac)
  );
  ////////////////////////////////////////////////////////////////////
  // sequencer: opcode cycle, operand cycles, address cycle
  always @(posedge clk) begin
    if (!nrst) begin
      state <= ST_OPC;
      opcode <= `OP_NOP;
      bytes_left <= 2'h0;
      opnd_first <= 8'h00;
      fetch_addr <= `PC_RESET;
      acc <= `ACC_RESET;
      psw <= `PSW_RESET;
      instr_done <= 1'b0;
    end else begin
      instr_done <= 1'b0;
      if (cycle_end) begin
        case (state)
          ST_OPC: begin
            opcode <= code_sync;
            fetch_addr <= fetch_addr + 16'h0001; // RULE2
            if (next_len == 2'h1) begin
              instr_done <= 1'b1; // RULE3 RULE8
              exec_one(code_sync, reg_operand);
            end else begin
              bytes_left <= next_len - 2'h1;
              state <= ST_OPND;
            end
          end
          ST_OPND: begin
            // keep the first operand byte; a long jump needs it as the high half
            if (bytes_left == next_len - 2'h1) begin
              opnd_first <= code_sync; // RULE4
            end
            fetch_addr <= fetch_addr + 16'h0001; // RULE2
            bytes_left <= bytes_left - 2'h1;
            if (bytes_left == 2'h1) begin
              if (next_jump) begin
                state <= ST_CALC; // RULE4
              end else begin
                state <= ST_OPC;
                instr_done <= 1'b1; // RULE3
                exec_two(code_sync);
              end
            end
          end
          ST_CALC: begin
            // target from operand bytes, no fetch this cycle
            state <= ST_OPC;
            instr_done <= 1'b1; // RULE4
            if (opcode == `OP_SJMP) begin
              fetch_addr <= fetch_addr + {{8{opnd_first[7]}}, opnd_first};
            end else if (opcode == `OP_LJMP || opcode == `OP_LCALL) begin
              fetch_addr <= {opnd_first, code_sync};
            end else begin
              fetch_addr <= {fetch_addr[15:11], opcode[7:5], opnd_first};
            end
          end
          default: state <= ST_OPC;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // one-byte execution: register adds, carry ops, rotates through carry, mul and div flags
  task exec_one;
    input [7:0] op;
    input [7:0] rv;
    reg [8:0] s;
    reg [8:0] sc;
    reg [4:0] n;
    reg [4:0] nc;
    begin
      s = {1'b0, acc} + {1'b0, rv};
      sc = s + {8'h00, psw[7]};
      n = {1'b0, acc[3:0]} + {1'b0, rv[3:0]};
      nc = n + {4'h0, psw[7]};
      if (op[7:4] == `HI_ADD && (op[3] || op[3:1] == 3'h3)) begin
        acc <= s[7:0]; // RULE6
        psw[0] <= ^s[7:0]; // RULE5
        psw[7] <= s[8]; // RULE7
        psw[6] <= n[4];
        psw[2] <= (acc[7] == rv[7]) && (s[7] != acc[7]);
      end else if (op[7:4] == `HI_ADDC && (op[3] || op[3:1] == 3'h3)) begin
        acc <= sc[7:0]; // RULE6
        psw[0] <= ^sc[7:0]; // RULE5
        psw[7] <= sc[8]; // RULE7
        psw[6] <= nc[4];
        psw[2] <= (acc[7] == rv[7]) && (sc[7] != acc[7]);
      end else if (op == `OP_CLR_C) begin
        psw[7] <= 1'b0; // RULE7
      end else if (op == `OP_SETB_C) begin
        psw[7] <= 1'b1; // RULE7
      end else if (op == `OP_CPL_C) begin
        psw[7] <= ~psw[7]; // RULE7
      end else if (op == `OP_RRC) begin
        acc <= {psw[7], acc[7:1]}; // RULE7
        psw[0] <= ^{psw[7], acc[7:1]}; // RULE5
        psw[7] <= acc[0];
      end else if (op == `OP_RLC) begin
        acc <= {acc[6:0], psw[7]}; // RULE7
        psw[0] <= ^{acc[6:0], psw[7]}; // RULE5
        psw[7] <= acc[7];
      end else if (op == `OP_MUL || op == `OP_DIV) begin
        psw[7] <= 1'b0; // RULE7
        psw[2] <= (op == `OP_DIV) ? (reg_operand == 8'h00) : (acc != 8'h00 && rv > 8'h01);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  // two-byte execution: immediate and direct adds, subtract with borrow
  task exec_two;
    input [7:0] imm;
    begin
      if (alu_sel != 3'h7) begin
        acc <= alu_res; // RULE6 RULE5
        psw[0] <= ^alu_res; // RULE5
        psw[7] <= alu_cy; // RULE7
        psw[6] <= alu_ac;
        psw[2] <= alu_ov;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  // phase shown as a clock count within the machine cycle
  always @(posedge clk) begin
    if (!nrst) begin
      phase_full <= 3'h0;
    end else begin
      phase_full <= (phase == `PHASE_LAST) ? 3'h0 : {1'b0, phase + 2'h1};
    end
  end
endmodule

/* File: dv/seq_monitor.sv */
// checker for the instruction sequencer: phase, fetch and completion timing
// assumes it is bound to instr_seq and sees only its ports
`timescale 1ns/1ps
module seq_monitor (
  input wire clk,
  input wire nrst,
  input wire fetch_req,
  input wire [7:0] acc,
  input wire [7:0] psw,
  input wire [2:0] phase_full,
  input wire cycle_end,
  input wire instr_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  a_phase_step: assert property (
    $past(nrst) |-> phase_full == (($past(phase_full) + 3'h1) & 3'h3))
    else $error("phase counter did not step by one");
  a_end_on_last: assert property (
    cycle_end == (phase_full == 3'h3)) else $error("cycle end off the last phase");
  a_fetch_phase0: assert property (
    fetch_req |-> phase_full == 3'h0) else $error("fetch outside phase zero");
  a_one_fetch: assert property (
    fetch_req |=> !fetch_req [*3]) else $error("two fetches in one cycle");
  a_done_after_end: assert property (
    instr_done |-> $past(cycle_end)) else $error("done not after a cycle end");
  a_done_spacing: assert property (
    instr_done |=> !instr_done [*3]) else $error("instructions closer than four clocks");
  a_acc_holds: assert property (
    !instr_done |-> $stable(acc)) else $error("accumulator moved between instructions");
  a_flags_hold: assert property (
    !instr_done |-> $stable(psw)) else $error("flags moved between instructions");
  // main scenarios reached
  c_done: cover property (instr_done);
  c_fetch: cover property (fetch_req);
  c_carry: cover property (instr_done && psw[7]);
endmodule
bind instr_seq seq_monitor mon (.clk(clk), .nrst(nrst), .fetch_req(fetch_req), .acc(acc),
  .psw(psw), .phase_full(phase_full), .cycle_end(cycle_end), .instr_done(instr_done));

/* File: dv/prog_mem.sv */
// program memory model feeding code bytes to the sequencer
// assumes one fetch per machine cycle; the byte is held until the next fetch
`timescale 1ns/1ps
module prog_mem (
  input wire clk,
  input wire fetch_req,
  input wire [15:0] fetch_addr,
  output reg [7:0] code_data
);
  reg [7:0] mem [0:255];
  integer i;
  // empty memory reads as no-operation
  initial begin
    code_data = 8'h00;
    for (i = 0; i < 256; i = i + 1) mem[i] = 8'h00;
  end
  // byte launched after the fetch clock, stable through the rest of the cycle
  always @(posedge clk) begin
    if (fetch_req) code_data <= mem[fetch_addr[7:0]];
  end
endmodule

/* File: dv/testbench.sv */
// testbench for the instruction sequencer with a program memory model
// assumes 200 MHz clock and a program loaded while reset is held
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_operand = 8'h88;
  wire [7:0] code_data;
  wire [15:0] fetch_addr;
  wire fetch_req;
  wire [7:0] acc;
  wire [7:0] psw;
  wire [2:0] phase_full;
  wire cycle_end;
  wire instr_done;
  int bad_count = 0;
  int comparisons = 0;
  // program bytes, first byte in the top slice; long jump to 0x0020 at the end
  localparam logic [8*17-1:0] prog = {8'h00, 8'h28, 8'h2f, 8'h3f, 8'h26, 8'h24, 8'h05, 8'h25,
    8'h30, 8'hd3, 8'h35, 8'h00, 8'hc3, 8'hb3, 8'h02, 8'h00, 8'h20};
  always #2.5 clk = ~clk;
  instr_seq uut (.clk(clk), .nrst(nrst), .code_data(code_data), .reg_operand(reg_operand),
    .fetch_addr(fetch_addr), .fetch_req(fetch_req), .acc(acc), .psw(psw),
    .phase_full(phase_full), .cycle_end(cycle_end), .instr_done(instr_done));
  prog_mem pmem (.clk(clk), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .code_data(code_data));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // wait for the next completion, then check result, clocks and fetches
  task step(input logic [7:0] ea, input logic [7:0] ep, input int ec, input int ef);
    int n;
    int f;
    n = 0;
    f = 0;
    do begin
      @(negedge clk);
      n++;
      if (fetch_req === 1'b1) f++;
    end while (instr_done !== 1'b1 && n < 40);
    chk(acc, ea);
    chk(psw, ep);
    if (ec > 0) begin
      chk(16'(n), 16'(ec));
      chk(16'(f), 16'(ef));
    end
  endtask
  task report_and_stop;
    if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reg_forms;
    step(8'h00, 8'h00, 0, 0);
    step(8'h88, 8'h00, 4, 1);
    step(8'h10, 8'hc5, 4, 1);
    step(8'h99, 8'h00, 4, 1);
    step(8'h21, 8'hc4, 4, 1);
  endtask
  task t_two_byte;
    step(8'h26, 8'h01, 8, 2);
    step(8'hae, 8'h01, 8, 2);
  endtask
  task t_carry_ops;
    step(8'hae, 8'h81, 4, 1);
    step(8'h37, 8'hc5, 8, 2);
    step(8'h37, 8'h45, 4, 1);
    step(8'h37, 8'hc5, 4, 1);
  endtask
  task t_jumps;
    step(8'h37, 8'hc5, 16, 3);
    step(8'h37, 8'hc5, 12, 2);
    step(8'hbf, 8'h01, 4, 1);
    chk(fetch_addr, 16'h0025);
    step(8'hff, 8'h80, 8, 2);
  endtask
  // reset in mid-run clears state and restarts from address zero
  task t_reset_again;
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    chk(acc, 16'h0000);
    chk(psw, 16'h0000);
    chk(fetch_req, 16'h0000);
    chk(instr_done, 16'h0000);
    chk(fetch_addr, 16'h0000);
    nrst = 1'b1;
    step(8'h00, 8'h00, 0, 0);
    step(8'h88, 8'h00, 4, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog against a hung sequencer
  initial begin
    #5000;
    bad_count++;
    report_and_stop();
  end
  // load program, release reset, run the scenarios
  initial begin
    @(negedge clk);
    for (int i = 0; i < 17; i++) pmem.mem[i] = prog[8*(16-i) +: 8];
    pmem.mem[32] = 8'h80;
    pmem.mem[33] = 8'h02;
    pmem.mem[36] = 8'h28;
    pmem.mem[37] = 8'h94;
    pmem.mem[38] = 8'hc0;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    t_reg_forms();
    t_two_byte();
    t_carry_ops();
    t_jumps();
    t_reset_again();
    report_and_stop();
  end
endmodule
